// *** pilot_scheme_trip_logic.sv ***
// pilot scheme trip logic with pickup/dropout timers and AXI4-Lite registers
//
// Chosen here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
`include "pilot_consts.svh"

module pilot_pd_timer (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic tick,
    input wire logic inLevel,
    input wire logic [`TIMER_W-1:0] pickup,
    input wire logic [`TIMER_W-1:0] dropout,
    output logic outLevel
);
    logic [`TIMER_W-1:0] cnt_ff;
    logic out_ff;
    logic [`TIMER_W-1:0] limit;

    assign limit = inLevel ? pickup : dropout;
    assign outLevel = out_ff;

    // output follows input only after the delay in ticks
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cnt_ff <= `ZERO_MS;
            out_ff <= 1'b0;
        end
        else if (inLevel == out_ff)
            cnt_ff <= `ZERO_MS; // [R24]
        else if (cnt_ff >= limit)
        begin
            out_ff <= inLevel; // [R24]
            cnt_ff <= `ZERO_MS;
        end
        else if (tick)
            cnt_ff <= cnt_ff + 16'h0001;
    end
endmodule : pilot_pd_timer

// Behaviour
// R01: overreach scheme trip feeds guard timer, keys
// R02: overreach comparer: trip, permission, no out-of-step
// R03: every trip gated by fault detector
// R04: pickup delay rides through spurious permissions
// R05: guard plus ride-through stop reversal trips
// R06: overreach three-terminal permission is AND
// R07: open breaker keys transmitter continuously
// R08: two breakers: AND of per-pole opens
// R09: underreach zone 1 trips directly and keys
// R10: underreach overreach trips only with permission
// R11: underreach three-terminal receivers are ORed
// R12: no open keying, underreach two receivers
// R13: blocking overreach inhibits blocks, stops carrier
// R14: blocking comparer then coordination pickup delay
// R15: block keys carrier; received or local block inhibits
// R16: ground carrier start chosen by variant
// R17: ground block persisting 25 ms extends 30 ms
// R18: distance block dropout extension
// R19: trip functions suppress or reset blocking
// R20: three-terminal blocking uses both receivers
// R21: transmitter stop forces transmitter off
// R22: pilot disable turns off pilot logic
// R23: distance extension 30 ms, 60 ms hybrid three-terminal
// R24: timers are tick pickup and dropout
module pilot_scheme_trip_logic #(
    parameter int unsigned TICK_CYCLES = `TICK_PERIOD_NS / `CLK_PERIOD_NS
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire pilot_pkg::meas_s measIn,
    input wire pilot_pkg::pins_s pinIn,
    output logic tripOut,
    output logic txKey,
    output logic carrierStop,
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp
);
    function automatic logic isReg(input logic [7:0] addr, input logic [7:0] off);
        isReg = (addr[7:2] == off[7:2]);
    endfunction : isReg

    function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] data,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
            if (strb[i])
                res[i*8 +: 8] = data[i*8 +: 8];
        mergeBytes = res;
    endfunction : mergeBytes

    // pin synchroniser: rise taken once stages two and three agree high, fall as soon as they differ
    logic [`PIN_W-1:0] s1_ff, s2_ff, s3_ff, pinF_ff;
    pilot_pkg::pins_s pin;
    assign pin = pilot_pkg::pins_s'(pinF_ff);

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s1_ff <= 10'h000;
            s2_ff <= 10'h000;
            s3_ff <= 10'h000;
            pinF_ff <= 10'h000;
        end
        else
        begin
            s1_ff <= pinIn;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            pinF_ff <= (s2_ff & s3_ff) | (pinF_ff & ~(s2_ff ^ s3_ff));
        end
    end

    // 1 ms tick
    logic [31:0] divCnt_ff;
    logic tick_ff;
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            divCnt_ff <= 32'h0000_0000;
            tick_ff <= 1'b0;
        end
        else if (divCnt_ff >= 32'(TICK_CYCLES - 1))
        begin
            divCnt_ff <= 32'h0000_0000;
            tick_ff <= 1'b1;
        end
        else
        begin
            divCnt_ff <= divCnt_ff + 32'h0000_0001;
            tick_ff <= 1'b0;
        end
    end

    // settings
    logic [31:0] ctrl_ff, ride_ff, guard_ff;
    pilot_pkg::scheme_e scheme;
    logic isOver, isUnder, isBlk, permissive, threeTerm, twoBrk, under3, dis;
    assign scheme = pilot_pkg::scheme_e'(ctrl_ff[`F_SCHEME]);
    assign isOver = (scheme == pilot_pkg::SCH_OVER) || (scheme == pilot_pkg::SCH_HYBRID);
    assign isUnder = (scheme == pilot_pkg::SCH_UNDER);
    assign isBlk = (scheme == pilot_pkg::SCH_BLOCK1) || (scheme == pilot_pkg::SCH_BLOCK2)
                   || (scheme == pilot_pkg::SCH_BLOCK3);
    assign permissive = isOver || isUnder;
    assign threeTerm = (ctrl_ff[`F_RCVR] == `RCVR_TWO);
    assign twoBrk = ctrl_ff[`F_TWO_BRK];
    assign under3 = isUnder && threeTerm; // [R12]
    assign dis = pin.pilotDisable; // [R22]

    // measuring-function combinations
    logic overAny, zone1Any, lineOpen;
    assign overAny = (|measIn.overTrip) | measIn.gndDirTrip; // [R01]
    assign zone1Any = |measIn.zone1Trip;
    assign lineOpen = (&pin.brk1Open) & (~twoBrk | (&pin.brk2Open)); // [R08]

    // receiver combinations
    logic permitOver, permitUnder, rxBlock;
    assign permitOver = threeTerm ? (pin.rx1 & pin.rx2) : pin.rx1; // [R06]
    assign permitUnder = threeTerm ? (pin.rx1 | pin.rx2) : pin.rx1; // [R11]
    assign rxBlock = threeTerm ? (pin.rx1 | pin.rx2) : pin.rx1; // [R20]

    // timers
    logic guardOut, rideOut, gndPersist, gndExt, distExt, rideIn;
    logic distBlkGate, gndBlkGate;
    logic [`TIMER_W-1:0] distDrop;
    assign distDrop = (scheme == pilot_pkg::SCH_HYBRID && threeTerm)
                      ? `DIST_EXTEND3_MS : `DIST_EXTEND_MS; // [R23]

    pilot_pd_timer u_guard (
        .ref_clk(ref_clk), .resetn(resetn), .tick(tick_ff), .inLevel(overAny),
        .pickup(guard_ff[`F_PU]), .dropout(guard_ff[`F_DO]), .outLevel(guardOut)); // [R01] [R05]
    pilot_pd_timer u_ride (
        .ref_clk(ref_clk), .resetn(resetn), .tick(tick_ff), .inLevel(rideIn),
        .pickup(ride_ff[`F_PU]), .dropout(ride_ff[`F_DO]), .outLevel(rideOut)); // [R04] [R14]
    pilot_pd_timer u_gnd_persist (
        .ref_clk(ref_clk), .resetn(resetn), .tick(tick_ff), .inLevel(gndBlkGate),
        .pickup(`GND_PERSIST_MS), .dropout(`ZERO_MS), .outLevel(gndPersist)); // [R17]
    pilot_pd_timer u_gnd_extend (
        .ref_clk(ref_clk), .resetn(resetn), .tick(tick_ff), .inLevel(gndPersist),
        .pickup(`ZERO_MS), .dropout(`GND_EXTEND_MS), .outLevel(gndExt)); // [R17]
    pilot_pd_timer u_dist_extend (
        .ref_clk(ref_clk), .resetn(resetn), .tick(tick_ff), .inLevel(distBlkGate),
        .pickup(`ZERO_MS), .dropout(distDrop), .outLevel(distExt)); // [R18]

    // permissive comparer
    logic permComp;
    assign permComp = ~measIn.outOfStep
                      & (isOver ? (guardOut & permitOver) : (overAny & permitUnder)); // [R02] [R10]

    // blocking functions, suppressed or reset by trip functions
    logic blockLocal, blkComp, gndStart;
    assign distBlkGate = (|measIn.distBlock) & ~overAny; // [R19]
    assign gndBlkGate = measIn.groundBlockOc & measIn.negSeqBlock & ~overAny; // [R13]
    assign blockLocal = (distBlkGate | distExt | gndBlkGate | gndExt) & ~overAny; // [R18] [R19]
    assign blkComp = overAny & ~rxBlock & ~blockLocal & ~measIn.outOfStep; // [R14] [R15]
    assign gndStart = (scheme == pilot_pkg::SCH_BLOCK1) ? (measIn.groundBlockOc & measIn.negSeqBlock)
                    : (scheme == pilot_pkg::SCH_BLOCK2) ? measIn.faultDetector
                    : (scheme == pilot_pkg::SCH_BLOCK3) ? measIn.groundBlockOc : 1'b0; // [R16]

    assign rideIn = isBlk ? blkComp : (permissive & permComp); // [R04]

    // outputs
    logic tripSig, permKey, carStart, nxt_trip, nxt_key, nxt_stop;
    logic tripOut_ff, txKey_ff, carrierStop_ff;
    assign tripSig = rideOut | (isUnder & zone1Any); // [R09]
    assign nxt_trip = tripSig & measIn.faultDetector & ~dis & (permissive | isBlk); // [R03] [R22]
    assign permKey = overAny | (isUnder & zone1Any) | (lineOpen & ~under3); // [R07] [R09] [R12]
    assign carStart = blockLocal | (gndStart & ~overAny); // [R15] [R16]
    assign nxt_key = ~pin.txStop & ~dis
                     & ((permissive & permKey) | (isBlk & carStart)); // [R21] [R22]
    assign nxt_stop = isBlk & (overAny | pin.txStop | dis); // [R13] [R21]

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            tripOut_ff <= 1'b0;
            txKey_ff <= 1'b0;
            carrierStop_ff <= 1'b0;
        end
        else
        begin
            tripOut_ff <= nxt_trip;
            txKey_ff <= nxt_key;
            carrierStop_ff <= nxt_stop;
        end
    end
    assign tripOut = tripOut_ff;
    assign txKey = txKey_ff;
    assign carrierStop = carrierStop_ff;

    // AXI4-Lite slave
    logic awready_ff, wready_ff, awGot_ff, wGot_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic [7:0] awAddr_ff;
    logic [31:0] wData_ff, rdata_ff;
    logic [3:0] wStrb_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic doWrite, wrMapped, rdMapped;
    logic [31:0] status, rdNext;

    assign doWrite = awGot_ff & wGot_ff;
    assign wrMapped = isReg(awAddr_ff, `ADDR_CTRL) | isReg(awAddr_ff, `ADDR_RIDE)
                      | isReg(awAddr_ff, `ADDR_GUARD) | isReg(awAddr_ff, `ADDR_STATUS);
    assign rdMapped = isReg(araddr, `ADDR_CTRL) | isReg(araddr, `ADDR_RIDE)
                      | isReg(araddr, `ADDR_GUARD) | isReg(araddr, `ADDR_STATUS);
    assign status = {9'h000, pinF_ff, 6'h00, rideOut, blockLocal, blkComp, permComp,
                     tripOut_ff, txKey_ff, carrierStop_ff};
    assign rdNext = isReg(araddr, `ADDR_CTRL) ? ctrl_ff
                  : isReg(araddr, `ADDR_RIDE) ? ride_ff
                  : isReg(araddr, `ADDR_GUARD) ? guard_ff
                  : isReg(araddr, `ADDR_STATUS) ? status : 32'h0000_0000;

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
            awGot_ff <= 1'b0;
            wGot_ff <= 1'b0;
            awAddr_ff <= 8'h00;
            wData_ff <= 32'h0000_0000;
            wStrb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= `RESP_OKAY;
        end
        else
        begin
            if (awvalid && awready_ff)
            begin
                awready_ff <= 1'b0;
                awGot_ff <= 1'b1;
                awAddr_ff <= awaddr;
            end
            if (wvalid && wready_ff)
            begin
                wready_ff <= 1'b0;
                wGot_ff <= 1'b1;
                wData_ff <= wdata;
                wStrb_ff <= wstrb;
            end
            if (doWrite)
            begin
                awGot_ff <= 1'b0;
                wGot_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= wrMapped ? `RESP_OKAY : `RESP_DECERR;
            end
            if (bvalid_ff && bready)
            begin
                bvalid_ff <= 1'b0;
                awready_ff <= 1'b1;
                wready_ff <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl_ff <= `CTRL_RESET;
            ride_ff <= `RIDE_RESET;
            guard_ff <= `GUARD_RESET;
        end
        else if (doWrite)
        begin
            if (isReg(awAddr_ff, `ADDR_CTRL))
                ctrl_ff <= mergeBytes(ctrl_ff, wData_ff, wStrb_ff);
            if (isReg(awAddr_ff, `ADDR_RIDE))
                ride_ff <= mergeBytes(ride_ff, wData_ff, wStrb_ff);
            if (isReg(awAddr_ff, `ADDR_GUARD))
                guard_ff <= mergeBytes(guard_ff, wData_ff, wStrb_ff);
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= `RESP_OKAY;
        end
        else if (arvalid && arready_ff)
        begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rdata_ff <= rdNext;
            rresp_ff <= rdMapped ? `RESP_OKAY : `RESP_DECERR;
        end
        else if (rvalid_ff && rready)
        begin
            rvalid_ff <= 1'b0;
            arready_ff <= 1'b1;
        end
    end

    assign awready = awready_ff;
    assign wready = wready_ff;
    assign bvalid = bvalid_ff;
    assign bresp = bresp_ff;
    assign arready = arready_ff;
    assign rvalid = rvalid_ff;
    assign rdata = rdata_ff;
    assign rresp = rresp_ff;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    a_trip_fault_gate: // [R03]
        assert property (tripOut |-> $past(measIn.faultDetector)) else $error("trip without fault detector");
    a_disable_all_quiet: // [R22]
        assert property ($past(pin.pilotDisable) |-> !tripOut && !txKey) else $error("pilot active while disabled");
    a_stop_forces_off: // [R21]
        assert property ($past(pin.txStop) |-> !txKey && (!$past(isBlk) || carrierStop))
        else $error("transmitter not off on stop");
    a_block_trip_stop: // [R13]
        assert property ($past(isBlk) && $past(overAny) |-> carrierStop && !blockLocal)
        else $error("carrier not stopped by overreach");
    a_zone1_direct_trip: // [R09]
        assert property (isUnder && zone1Any && measIn.faultDetector && !pin.pilotDisable |=> tripOut)
        else $error("zone 1 did not trip directly");
    a_open_end_key: // [R07]
        assert property (permissive && lineOpen && !under3 && !pin.txStop && !pin.pilotDisable |=> txKey)
        else $error("open breaker not keying");
    a_under3_no_open: // [R12]
        assert property (under3 && !overAny && !zone1Any |=> !txKey) else $error("open keying not inhibited");
    a_over_rx_and: // [R06]
        assert property (isOver && threeTerm && !(pin.rx1 && pin.rx2) |-> !permComp)
        else $error("three-terminal permission not ANDed");
    a_rx_block_cmp: // [R15]
        assert property (isBlk && rxBlock |-> !blkComp && !rideIn) else $error("received block ignored");
    a_ride_pickup: // [R04]
        assert property ($rose(rideOut) |-> $past(rideIn)) else $error("ride-through rose without input");

    c_over_trip: cover property (isOver && $rose(tripOut));
    c_block_key: cover property (isBlk && $rose(txKey));
    c_ground_extend: cover property ($fell(gndPersist) && gndExt);
endmodule : pilot_scheme_trip_logic

// *** pilot_consts.svh ***
// constants for the pilot scheme trip logic: offsets, fields, reset values, times
`ifndef PILOT_CONSTS_SVH
`define PILOT_CONSTS_SVH

`define CLK_PERIOD_NS 10
`define TICK_PERIOD_NS 1000000
`define TIMER_W 16

// times in ms; timers count 1 ms ticks
`define GND_PERSIST_MS 16'h0019
`define GND_EXTEND_MS 16'h001E
`define DIST_EXTEND_MS 16'h001E
`define DIST_EXTEND3_MS 16'h003C
`define ZERO_MS 16'h0000

`define ADDR_CTRL 8'h00
`define ADDR_RIDE 8'h04
`define ADDR_GUARD 8'h08
`define ADDR_STATUS 8'h0C

`define CTRL_RESET 32'h0000_0011
`define RIDE_RESET 32'h0000_0004
`define GUARD_RESET 32'h0002_0000

`define F_SCHEME 2:0
`define F_RCVR 5:4
`define F_TWO_BRK 8
`define F_PU 15:0
`define F_DO 31:16
`define RCVR_TWO 2'h2

`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3
`define PIN_W 10

`endif

// *** pilot_pkg.sv ***
// types shared by the pilot scheme trip logic
package pilot_pkg;

    typedef enum logic [2:0] {
        SCH_OFF = 3'b000,
        SCH_OVER = 3'b001,
        SCH_UNDER = 3'b010,
        SCH_HYBRID = 3'b011,
        SCH_BLOCK1 = 3'b100,
        SCH_BLOCK2 = 3'b101,
        SCH_BLOCK3 = 3'b110
    } scheme_e;

    // outputs of the local measuring functions, same clock
    typedef struct packed {
        logic [5:0] zone1Trip;
        logic [5:0] overTrip;
        logic gndDirTrip;
        logic [5:0] distBlock;
        logic groundBlockOc;
        logic negSeqBlock;
        logic faultDetector;
        logic outOfStep;
    } meas_s;

    // contact converter pins, asynchronous
    typedef struct packed {
        logic rx1;
        logic rx2;
        logic [2:0] brk1Open;
        logic [2:0] brk2Open;
        logic txStop;
        logic pilotDisable;
    } pins_s;

endpackage : pilot_pkg

// *** remote_terminal.sv ***
// remote line terminal model across the channel
`timescale 1ns/100ps
module remote_terminal #(
    parameter int unsigned DELAY = 2
) (
    input wire logic ref_clk,
    input wire logic localKey,
    input wire logic sendKey,
    output logic rxOut,
    output logic keySeen
);
    logic [DELAY-1:0] fwdPipe;
    logic [DELAY-1:0] backPipe;
    initial
    begin
        fwdPipe = '0;
        backPipe = '0;
    end
    // channel delay both ways
    always @(posedge ref_clk)
    begin
        fwdPipe <= {fwdPipe[DELAY-2:0], sendKey};
        backPipe <= {backPipe[DELAY-2:0], localKey};
    end
    assign rxOut = fwdPipe[DELAY-1];
    assign keySeen = backPipe[DELAY-1];
endmodule : remote_terminal

// *** tb_pilot_scheme_trip_logic.sv ***
// testbench for the pilot scheme trip logic
`timescale 1ns/100ps
`include "pilot_consts.svh"
module tb_pilot_scheme_trip_logic;
    typedef struct packed {
        logic [2:0] sch;
        logic [1:0] rc;
        logic [8:0] inp; // ov z1 flt oos rx1 rx2 db gb ns
        logic [2:0] exp; // trip key stop
        logic [2:0] msk;
    } row_s;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    pilot_pkg::meas_s measIn = '0;
    pilot_pkg::pins_s pinIn;
    logic sendA = 1'b0;
    logic sendB = 1'b0;
    logic [2:0] brk1 = 3'h0;
    logic [2:0] brk2 = 3'h0;
    logic stopIn = 1'b0;
    logic disIn = 1'b0;
    logic rxA;
    logic rxB;
    logic seenA;
    logic tripOut;
    logic txKey;
    logic carrierStop;
    logic awvalid = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic wvalid = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic [7:0] araddr = 8'h00;
    logic rready = 1'b0;
    logic awready;
    logic wready;
    logic bvalid;
    logic arready;
    logic rvalid;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [1:0] resp;
    logic [31:0] rd;
    int err_total = 0;
    int n_tests = 0;
    int cyc = 0;
    row_s rows [20];

    initial
    begin
        forever #5 ref_clk = ~ref_clk;
    end

    assign pinIn = '{rx1: rxA, rx2: rxB, brk1Open: brk1, brk2Open: brk2, txStop: stopIn, pilotDisable: disIn};

    pilot_scheme_trip_logic #(.TICK_CYCLES(10)) u_pilot_scheme_trip_logic (
        .ref_clk(ref_clk), .resetn(resetn), .measIn(measIn), .pinIn(pinIn),
        .tripOut(tripOut), .txKey(txKey), .carrierStop(carrierStop),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
        .wdata(wdata), .wstrb(4'hF), .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
        .rdata(rdata), .rresp(rresp)
    );
    remote_terminal u_remote_terminal (.ref_clk(ref_clk), .localKey(txKey), .sendKey(sendA),
        .rxOut(rxA), .keySeen(seenA));
    remote_terminal u_remote_terminal_b (.ref_clk(ref_clk), .localKey(txKey), .sendKey(sendB),
        .rxOut(rxB), .keySeen());

    task results;
        $display("checks %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : results

    task check(input string name, input logic [31:0] seen, input logic [31:0] expv);
        n_tests++;
        if (seen !== expv)
        begin
            $display("Error %s expected %h seen %h", name, expv, seen);
            err_total++;
        end
    endtask : check

    task wt(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : wt

    task axiWrite(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        bready <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            if (awready === 1'b1)
                awvalid <= 1'b0;
            if (wready === 1'b1)
                wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask : axiWrite

    task axiRead(input logic [7:0] a);
        @(posedge ref_clk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            if (arready === 1'b1)
                arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask : axiRead

    task applyIn(input logic [8:0] v);
        @(posedge ref_clk);
        measIn.overTrip <= {5'h00, v[8]};
        measIn.zone1Trip <= {5'h00, v[7]};
        measIn.faultDetector <= v[6];
        measIn.outOfStep <= v[5];
        sendA <= v[4];
        sendB <= v[3];
        measIn.distBlock <= {5'h00, v[2]};
        measIn.groundBlockOc <= v[1];
        measIn.negSeqBlock <= v[0];
    endtask : applyIn

    task keyChk(input logic [31:0] ctrl, input logic [2:0] b1, input logic [2:0] b2, input logic k);
        axiWrite(`ADDR_CTRL, ctrl);
        @(posedge ref_clk);
        brk1 <= b1;
        brk2 <= b2;
        wt(30);
        check("txKey", txKey, k);
    endtask : keyChk

    task pickChk(input logic [31:0] ctrl, input logic [8:0] v, input logic [31:0] ride, input logic [31:0] grd);
        axiWrite(`ADDR_RIDE, ride);
        axiWrite(`ADDR_GUARD, grd);
        axiWrite(`ADDR_CTRL, ctrl);
        applyIn(v);
        wt(40);
        check("trip early", tripOut, 1'b0);
        wt(80);
        check("trip late", tripOut, 1'b1);
        applyIn(9'h000);
        wt(700);
    endtask : pickChk

    task extChk(input logic [31:0] ctrl, input logic [8:0] v, input int hold, input int hi, input int lo,
        input int b);
        axiWrite(`ADDR_CTRL, ctrl);
        applyIn(v);
        wt(hold);
        applyIn(9'h000);
        wt(hi);
        axiRead(`ADDR_STATUS);
        check("held", rd[b], 1'b1);
        wt(lo - hi);
        axiRead(`ADDR_STATUS);
        check("dropped", rd[b], 1'b0);
    endtask : extChk

    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            err_total++;
            results();
        end
    end

    initial
    begin
        rows[0] = '{3'h1, 2'h1, 9'b101010000, 3'b110, 3'b110};
        rows[1] = '{3'h1, 2'h1, 9'b101000000, 3'b010, 3'b110};
        rows[2] = '{3'h1, 2'h1, 9'b100010000, 3'b010, 3'b110};
        rows[3] = '{3'h1, 2'h1, 9'b101110000, 3'b000, 3'b100};
        rows[4] = '{3'h1, 2'h2, 9'b101010000, 3'b000, 3'b100};
        rows[5] = '{3'h1, 2'h2, 9'b101011000, 3'b100, 3'b100};
        rows[6] = '{3'h2, 2'h1, 9'b011000000, 3'b110, 3'b110};
        rows[7] = '{3'h2, 2'h1, 9'b101000000, 3'b000, 3'b100};
        rows[8] = '{3'h2, 2'h1, 9'b101010000, 3'b100, 3'b100};
        rows[9] = '{3'h2, 2'h2, 9'b101001000, 3'b100, 3'b100};
        rows[10] = '{3'h4, 2'h1, 9'b101000000, 3'b101, 3'b111};
        rows[11] = '{3'h4, 2'h1, 9'b101010000, 3'b000, 3'b100};
        rows[12] = '{3'h4, 2'h2, 9'b101001000, 3'b000, 3'b100};
        rows[13] = '{3'h4, 2'h1, 9'b001000100, 3'b010, 3'b110};
        rows[14] = '{3'h4, 2'h1, 9'b101000100, 3'b100, 3'b100};
        rows[15] = '{3'h4, 2'h1, 9'b000000011, 3'b010, 3'b010};
        rows[16] = '{3'h4, 2'h1, 9'b000000010, 3'b000, 3'b010};
        rows[17] = '{3'h5, 2'h1, 9'b001000000, 3'b010, 3'b010};
        rows[18] = '{3'h6, 2'h1, 9'b000000010, 3'b010, 3'b010};
        rows[19] = '{3'h0, 2'h1, 9'b101010000, 3'b000, 3'b111};
        wt(6);
        resetn <= 1'b1;
        axiWrite(`ADDR_RIDE, 32'h0);
        axiWrite(`ADDR_GUARD, 32'h0);
        for (int i = 0; i < 20; i++)
        begin
            axiWrite(`ADDR_CTRL, {26'h0, rows[i].rc, 1'b0, rows[i].sch});
            applyIn(rows[i].inp);
            wt(30);
            check("row", {tripOut, txKey, carrierStop} & rows[i].msk, rows[i].exp & rows[i].msk);
            applyIn(9'h000);
            wt(700);
        end
        // second reset in mid-run
        resetn <= 1'b0;
        wt(6);
        check("reset outs", {tripOut, txKey, carrierStop, bvalid, rvalid, awready, arready}, 7'h03);
        resetn <= 1'b1;
        axiRead(`ADDR_CTRL);
        check("ctrl", rd, `CTRL_RESET);
        axiRead(`ADDR_RIDE);
        check("ride", rd, `RIDE_RESET);
        axiRead(`ADDR_GUARD);
        check("guard", rd, `GUARD_RESET);
        axiRead(8'h10);
        check("unmapped rd", rd, 32'h0);
        check("unmapped rresp", {30'h0, resp}, {30'h0, `RESP_DECERR});
        axiWrite(8'h40, 32'h0);
        check("unmapped wr", resp, `RESP_DECERR);
        axiWrite(`ADDR_STATUS, 32'hFFFF_FFFF);
        check("status wr", resp, `RESP_OKAY);
        axiWrite(`ADDR_GUARD, 32'h0);
        axiWrite(`ADDR_RIDE, 32'h0);
        keyChk(32'h011, 3'h7, 3'h0, 1'b1);
        keyChk(32'h111, 3'h7, 3'h0, 1'b0);
        keyChk(32'h111, 3'h7, 3'h7, 1'b1);
        keyChk(32'h022, 3'h7, 3'h7, 1'b0);
        keyChk(32'h012, 3'h7, 3'h7, 1'b1);
        keyChk(32'h011, 3'h0, 3'h0, 1'b0);
        applyIn(9'h100);
        wt(30);
        check("seen key", seenA, 1'b1);
        stopIn <= 1'b1;
        wt(30);
        check("txKey", txKey, 1'b0);
        check("seen key", seenA, 1'b0);
        stopIn <= 1'b0;
        applyIn(9'h150);
        disIn <= 1'b1;
        wt(30);
        check("disabled", {tripOut, txKey}, 2'h0);
        applyIn(9'h000);
        axiWrite(`ADDR_CTRL, 32'h014);
        wt(30);
        check("stop", carrierStop, 1'b1);
        disIn <= 1'b0;
        applyIn(9'h000);
        wt(700);
        axiWrite(`ADDR_RIDE, 32'h0000_0005);
        axiWrite(`ADDR_CTRL, 32'h011);
        applyIn(9'h150);
        wt(20);
        applyIn(9'h140);
        wt(60);
        check("spurious", tripOut, 1'b0);
        pickChk(32'h011, 9'h150, 32'h5, 32'h0);
        pickChk(32'h011, 9'h150, 32'h0, 32'h5);
        pickChk(32'h014, 9'h140, 32'h5, 32'h0);
        extChk(32'h014, 9'h004, 20, 200, 450, 5);
        extChk(32'h023, 9'h004, 20, 450, 800, 5);
        extChk(32'h014, 9'h003, 300, 200, 500, 1);
        results();
    end
endmodule : tb_pilot_scheme_trip_logic
